// ===== design/sdt_timing_counter.sv
// Purpose: Divider chain, quadrature coil drive and step gated distance count.
// Assumes: ref_clk_i is the 80 kHz reference, sampled as a synchronous level.
// Notes: Distance pulses leave one clock wide; the readout driver stretches them.
//
// Contract
// - Divide the 80 kHz reference by four to give the 20 kHz count clock.
// - Send the 20 kHz clock to the step counting and scaling logic.
// - Halve 20 kHz to 10 kHz, then halve again to 5 kHz.
// - NAND-decode 10 kHz and 5 kHz into early and late drive pulses.
// - Each drive pulse is high 50 us, a quarter of the period.
// - The late pulse starts 50 us after the early pulse, 90 degrees apart.
// - Both drive signals stay locked in quadrature while running.
// - Gate opens at lower threshold crossing and closes at upper crossing.
// - Only while the gate is open are 20 kHz pulses counted.
// - Every 1280 counted pulses give one meter increment.
// - Derive a clear pulse from the gate to reset the receiver.
// - Measure only on the second foot event; the first marks the minimum.
// - Repeat measure, count and clear for every step, then rearm.
// - Scale by a divide-by-ten stage then a divide-by-128 stage.
// - Time the clear pulse from the upper threshold crossing.
// - Repeat each meter increment to the readout after 90 ms.
`timescale 1ns/10ps
module sdt_timing_counter #(
    parameter int unsigned DELAY_CYC = sdt_pkg::DELAY_CYC_DEF
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Reference and receiver
    input wire logic ref_clk_i,
    input wire logic foot_evt_i,
    input wire sdt_pkg::sdt_thresh_t thresh_i,
    // Coil drive and divider outputs
    output sdt_pkg::sdt_drive_t drive_o,
    output logic clk20_o,
    output logic clk10_o,
    output logic clk5_o,
    // Step processing
    output logic gate_o,
    output logic step_rst_o,
    output logic meter_pulse_o
);
    import sdt_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ==========================================================
    // Divider chain
    logic ref_q_r;
    logic [REF_W-1:0] ref_cnt_r;
    logic q10_r;
    logic q5_r;
    wire ref_rise = ref_clk_i & ~ref_q_r;
    wire tick20 = ref_rise && (ref_cnt_r == REF_LAST);
    wire [REF_W-1:0] ref_cnt_nxt = ref_rise ? ref_cnt_r + 2'h1 : ref_cnt_r;
    wire q10_nxt = tick20 ? ~q10_r : q10_r;
    wire q5_nxt = (tick20 && q10_r) ? ~q5_r : q5_r;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ref_q_r <= 1'b0;
            ref_cnt_r <= REF_ZERO;
            q10_r <= 1'b0;
            q5_r <= 1'b0;
        end else begin
            ref_q_r <= ref_clk_i;
            ref_cnt_r <= ref_cnt_nxt;
            q10_r <= q10_nxt;
            q5_r <= q5_nxt;
        end
    end

    // ==========================================================
    // Quadrature drive decode
    // Both pulses come from one counter, so they can never drift apart.
    wire early_n = ~(~q5_nxt & ~q10_nxt);
    wire late_n = ~(~q5_nxt & q10_nxt);
    sdt_drive_t drive_r;
    sdt_drive_t drive_nxt;
    assign drive_nxt.early = ~early_n;
    assign drive_nxt.late = ~late_n;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    assign drive_o = drive_r;
    assign clk20_o = ref_cnt_r[REF_W-1];
    assign clk10_o = q10_r;
    assign clk5_o = q5_r;

    // ==========================================================
    // Step sequence
    sdt_state_t st_r;
    sdt_state_t st_nxt;
    logic foot_q_r;
    logic [RST_W-1:0] rst_cnt_r;
    logic [RST_W-1:0] rst_cnt_nxt;
    wire foot_rise = foot_evt_i & ~foot_q_r;
    wire rst_done = (rst_cnt_r == RST_W'(1));

    always_comb begin
        st_nxt = st_r;
        rst_cnt_nxt = (rst_cnt_r != '0) ? rst_cnt_r - RST_W'(1) : rst_cnt_r;
        unique case (st_r)
            ST_WAIT_MIN: begin
                if (foot_rise) begin
                    st_nxt = ST_WAIT_JOIN;
                end
            end
            ST_WAIT_JOIN: begin
                if (foot_rise) begin
                    st_nxt = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (thresh_i.lo) begin
                    st_nxt = ST_GATE;
                end
            end
            ST_GATE: begin
                if (thresh_i.hi) begin
                    st_nxt = ST_CLEAR;
                    rst_cnt_nxt = RST_W'(RST_CYC);
                end
            end
            ST_CLEAR: begin
                if (rst_done) begin
                    st_nxt = ST_WAIT_MIN;
                end
            end
            default: begin
                st_nxt = ST_WAIT_MIN;
            end
        endcase
    end

    logic gate_r;
    logic step_rst_r;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_WAIT_MIN;
            foot_q_r <= 1'b0;
            rst_cnt_r <= '0;
            gate_r <= 1'b0;
            step_rst_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            foot_q_r <= foot_evt_i;
            rst_cnt_r <= rst_cnt_nxt;
            gate_r <= (st_nxt == ST_GATE);
            step_rst_r <= (st_nxt == ST_CLEAR);
        end
    end

    assign gate_o = gate_r;
    assign step_rst_o = step_rst_r;

    // ==========================================================
    // Distance scaling
    // The remainder is not cleared per step, so short steps still add up.
    logic [DIVA_W-1:0] div10_r;
    logic [DIVB_W-1:0] div128_r;
    wire cnt_en = tick20 && (st_r == ST_GATE);
    wire a_wrap = cnt_en && (div10_r == DIVA_LAST);
    wire meter_evt = a_wrap && (div128_r == DIVB_LAST);
    wire [DIVA_W-1:0] div10_nxt = a_wrap ? DIVA_ZERO :
        (cnt_en ? div10_r + 4'h1 : div10_r);
    wire [DIVB_W-1:0] div128_nxt = a_wrap ? div128_r + 7'h01 : div128_r;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            div10_r <= '0;
            div128_r <= '0;
        end else begin
            div10_r <= div10_nxt;
            div128_r <= div128_nxt;
        end
    end

    // ==========================================================
    // Readout delay
    // Two slots cover the one or two increments that can be pending within one readout delay.
    logic [NSLOT-1:0] busy_r;
    logic [NSLOT-1:0] busy_nxt;
    logic [SLOT_W-1:0] dly_r [NSLOT];
    logic [SLOT_W-1:0] dly_nxt [NSLOT];
    logic fire;
    logic meter_pulse_r;

    always_comb begin
        logic taken;
        taken = 1'b0;
        fire = 1'b0;
        for (int i = 0; i < NSLOT; i++) begin
            busy_nxt[i] = busy_r[i];
            dly_nxt[i] = dly_r[i];
            if (busy_r[i]) begin
                dly_nxt[i] = dly_r[i] - SLOT_W'(1);
                if (dly_r[i] == SLOT_W'(1)) begin
                    busy_nxt[i] = 1'b0;
                    fire = 1'b1;
                end
            end else if (meter_evt && !taken) begin
                busy_nxt[i] = 1'b1;
                dly_nxt[i] = SLOT_W'(DELAY_CYC);
                taken = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= '0;
            dly_r <= '{default: '0};
            meter_pulse_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            dly_r <= dly_nxt;
            meter_pulse_r <= fire;
        end
    end

    assign meter_pulse_o = meter_pulse_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    property p_ref_div;
        ref_rise |=> ref_cnt_r == $past(ref_cnt_r) + 2'h1;
    endproperty
    a_ref_div: assert property (p_ref_div) else $error("Reference divider missed a step.");

    property p_q10_toggle;
        tick20 |=> q10_r != $past(q10_r);
    endproperty
    a_q10_toggle: assert property (p_q10_toggle) else $error("10 kHz stage did not toggle.");

    property p_q5_toggle;
        (tick20 && q10_r) |=> q5_r != $past(q5_r);
    endproperty
    a_q5_toggle: assert property (p_q5_toggle) else $error("5 kHz stage did not toggle.");

    property p_drive_excl;
        !(drive_r.early && drive_r.late);
    endproperty
    a_drive_excl: assert property (p_drive_excl) else $error("Drive pulses overlap.");

    property p_late_follows;
        $fell(drive_r.early) |-> drive_r.late;
    endproperty
    a_late_follows: assert property (p_late_follows) else $error("Late pulse not adjacent.");

    property p_join;
        (st_r == ST_WAIT_MIN && foot_rise) |=> st_r == ST_WAIT_JOIN && !gate_r;
    endproperty
    a_join: assert property (p_join) else $error("First foot event opened the gate.");

    property p_no_count;
        (st_r != ST_GATE) |=> $stable(div10_r) && $stable(div128_r);
    endproperty
    a_no_count: assert property (p_no_count) else $error("Counted outside the gate.");

    property p_scale;
        a_wrap |=> div10_r == DIVA_ZERO && div128_r == $past(div128_r) + 7'h01;
    endproperty
    a_scale: assert property (p_scale) else $error("Scaling stages out of step.");

    property p_clear;
        (st_r == ST_GATE && thresh_i.hi) |=> step_rst_r && !gate_r;
    endproperty
    a_clear: assert property (p_clear) else $error("Upper crossing gave no clear.");

    property p_meter_load;
        (meter_evt && !(&busy_r) && !fire) |=> $countones(busy_r) == $countones($past(busy_r)) + 1;
    endproperty
    a_meter_load: assert property (p_meter_load) else $error("Increment not queued.");

endmodule

// ===== design/sdt_pkg.sv
// Purpose: Shared constants and types of the step distance timing counter.
// Assumes: One 200 MHz system clock; all inputs are synchronous to it.
// Notes: Long delays are cycle counts derived here from their printed times.
package sdt_pkg;

    // ==========================================================
    // Clock and divider chain
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned REF_HZ = 80_000;
    localparam int unsigned CNT_HZ = 20_000;
    localparam int unsigned REF_DIV = REF_HZ / CNT_HZ;
    localparam int REF_W = 2;
    localparam logic [REF_W-1:0] REF_LAST = REF_W'(REF_DIV - 1);
    localparam logic [REF_W-1:0] REF_ZERO = 2'h0;

    // ==========================================================
    // Drive phases within one 5 kHz period, 50 us each
    localparam logic [1:0] PH_EARLY = 2'h0;
    localparam logic [1:0] PH_LATE = 2'h1;

    // ==========================================================
    // Distance scaling, 1280 gated pulses per meter
    localparam int unsigned DIV_A = 10;
    localparam int unsigned DIV_B = 128;
    localparam int DIVA_W = 4;
    localparam int DIVB_W = 7;
    localparam logic [DIVA_W-1:0] DIVA_LAST = DIVA_W'(DIV_A - 1);
    localparam logic [DIVB_W-1:0] DIVB_LAST = DIVB_W'(DIV_B - 1);
    localparam logic [DIVA_W-1:0] DIVA_ZERO = 4'h0;

    // ==========================================================
    // Per-step clear pulse and readout delay
    localparam int unsigned RST_NS = 10_000;
    localparam int unsigned RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_W = 11;
    localparam int unsigned DELAY_MS = 90;
    localparam int unsigned DELAY_CYC_DEF = DELAY_MS * (CLK_HZ / 1000);
    localparam int SLOT_W = 25;
    localparam int NSLOT = 2;

    // ==========================================================
    // Types
    typedef struct packed {
        logic lo;
        logic hi;
    } sdt_thresh_t;

    typedef struct packed {
        logic early;
        logic late;
    } sdt_drive_t;

    typedef enum logic [2:0] {
        ST_WAIT_MIN,
        ST_WAIT_JOIN,
        ST_RAMP,
        ST_GATE,
        ST_CLEAR
    } sdt_state_t;

endpackage

// ===== verif/sdt_rx_model.sv
// Purpose: Behavioural receiver side that makes foot events and ramp threshold crossings.
// Assumes: Driven at the falling clock edge; ramp length is counted in 20 kHz ticks.
// Notes: The second foot event can be withheld to model a stride that never closes.
`timescale 1ns/10ps
module sdt_rx_model (
    // Clock and observed design outputs
    input wire logic clock_i,
    input wire logic clk20_i,
    input wire logic step_rst_i,
    // Receiver signals toward the design
    output logic foot_evt_o,
    output sdt_pkg::sdt_thresh_t thresh_o
);
    import sdt_pkg::*;

    // ==========================================================
    // Step sequence
    initial begin
        foot_evt_o = 1'b0;
        thresh_o = '0;
    end

    task automatic idle();
        foot_evt_o = 1'b0;
        thresh_o = '0;
    endtask

    task automatic pulse_foot();
        @(negedge clock_i) foot_evt_o = 1'b1;
        repeat (3) @(negedge clock_i);
        foot_evt_o = 1'b0;
        repeat (3) @(negedge clock_i);
    endtask

    // The ramp starts just after a tick, so gate edges stay well clear of counting edges.
    task automatic step(input int n, input bit closes);
        int k;
        pulse_foot();
        if (closes) pulse_foot();
        @(negedge clk20_i);
        @(negedge clock_i) thresh_o.lo = 1'b1;
        for (k = 0; k < n; k++) @(negedge clk20_i);
        @(negedge clock_i) thresh_o.hi = 1'b1;
        if (closes) begin
            wait (step_rst_i === 1'b1);
            @(negedge clock_i) thresh_o = '0;
            wait (step_rst_i === 1'b0);
        end else begin
            repeat (20) @(negedge clock_i);
            thresh_o = '0;
        end
        @(negedge clock_i);
    endtask
endmodule

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the step distance timing counter.
// Assumes: The reference period is four clocks, so one 20 kHz tick is 16 clocks.
// Notes: A fast reference keeps 1280-tick meters short; tick counts scale with it, but RST_CYC and DLY do not.
`timescale 1ns/10ps
module tb_top;
    import sdt_pkg::*;

    // ==========================================================
    // Clock, reset and design
    localparam int unsigned DLY = 50;
    typedef struct {int ticks; int meters;} sdt_row_t;
    logic clock_i, reset_n_i, ref_clk_i, foot_evt_i;
    logic [1:0] ref_cnt;
    sdt_thresh_t thresh_i;
    sdt_drive_t drive_o;
    logic clk20_o, clk10_o, clk5_o, gate_o, step_rst_o, meter_pulse_o;
    int n_fail, checks, n_met, base, i;
    logic [31:0] rst_len;
    logic [63:0] hist;
    logic c20_q, gate_seen;
    sdt_row_t rows [4] = '{'{1275, 0}, '{5, 1}, '{2560, 3}, '{10, 3}};

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    always @(negedge clock_i) ref_cnt <= ref_cnt + 2'h1;
    assign ref_clk_i = ref_cnt[1];

    sdt_timing_counter #(.DELAY_CYC(DLY)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .ref_clk_i(ref_clk_i), .foot_evt_i(foot_evt_i), .thresh_i(thresh_i),
        .drive_o(drive_o), .clk20_o(clk20_o), .clk10_o(clk10_o), .clk5_o(clk5_o),
        .gate_o(gate_o), .step_rst_o(step_rst_o), .meter_pulse_o(meter_pulse_o));

    sdt_rx_model rx (.clock_i(clock_i), .clk20_i(clk20_o), .step_rst_i(step_rst_o),
        .foot_evt_o(foot_evt_i), .thresh_o(thresh_i));

    // ==========================================================
    // Checking
    task automatic chk_num(input string name, input int exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Meter pulses must trail a tick by the readout delay; one cycle of slack either way.
    // Sampled at the falling edge, where the registered outputs have settled.
    always @(negedge clock_i) begin
        hist = {hist[62:0], c20_q & ~clk20_o};
        c20_q = clk20_o;
        if (gate_o === 1'b1) gate_seen = 1'b1;
        if (step_rst_o === 1'b1) begin
            if (rst_len == 0) chk_num("gate at clear", 0, {31'h0, gate_o});
            rst_len++;
        end else if (rst_len != 0) begin
            chk_num("clear length", RST_CYC, rst_len);
            rst_len = 0;
        end
        if (meter_pulse_o === 1'b1) begin
            n_met++;
            chk_num("meter delay", 1, {31'h0, hist[DLY-1] | hist[DLY] | hist[DLY+1]});
        end
    end

    task automatic chk_drive();
        int k, bad, n20, n10, n5;
        logic p20, p10, p5;
        bad = 0;
        n20 = 0;
        n10 = 0;
        n5 = 0;
        k = 0;
        while (drive_o.early !== 1'b0 && k < 200) begin
            @(negedge clock_i);
            k++;
        end
        // Keep the levels from just before the early rise, so the falls at that tick count.
        while (drive_o.early !== 1'b1 && k < 400) begin
            p20 = clk20_o;
            p10 = clk10_o;
            p5 = clk5_o;
            @(negedge clock_i);
            k++;
        end
        for (k = 0; k < 64; k++) begin
            if (drive_o.early !== (k < 16) || drive_o.late !== (k >= 16 && k < 32)) bad++;
            n20 += int'(p20 & ~clk20_o);
            n10 += int'(p10 & ~clk10_o);
            n5 += int'(p5 & ~clk5_o);
            p20 = clk20_o;
            p10 = clk10_o;
            p5 = clk5_o;
            @(negedge clock_i);
        end
        chk_num("drive pattern", 0, bad);
        chk_num("clk20 falls", 4, n20);
        chk_num("clk10 falls", 2, n10);
        chk_num("clk5 falls", 1, n5);
    endtask

    // ==========================================================
    // Stimulus
    initial begin
        reset_n_i = 1'b0;
        ref_cnt = 2'h0;
        n_fail = 0;
        checks = 0;
        n_met = 0;
        rst_len = 0;
        hist = '0;
        c20_q = 1'b0;
        gate_seen = 1'b0;
        repeat (3) @(negedge clock_i);
        reset_n_i = 1'b1;
        repeat (8) @(negedge clock_i);
        chk_drive();
        for (i = 0; i < 4; i++) begin
            rx.step(rows[i].ticks, 1'b1);
            repeat (DLY + 20) @(negedge clock_i);
            chk_num("meters", rows[i].meters, n_met);
        end
        chk_drive();
        gate_seen = 1'b0;
        rx.step(4, 1'b0);
        chk_num("gate without join", 0, {31'h0, gate_seen});
        chk_num("meters after lone event", 3, n_met);
        fork
            rx.step(3000, 1'b1);
            begin
                wait (gate_o === 1'b1);
                repeat (300 * 16) @(negedge clock_i);
            end
        join_any
        disable fork;
        reset_n_i = 1'b0;
        rx.idle();
        @(negedge clock_i);
        chk_num("outputs in reset", 0, {drive_o, clk20_o, clk10_o, clk5_o, gate_o,
            step_rst_o, meter_pulse_o});
        repeat (2) @(negedge clock_i);
        reset_n_i = 1'b1;
        repeat (8) @(negedge clock_i);
        base = n_met;
        rx.step(1000, 1'b1);
        repeat (DLY + 20) @(negedge clock_i);
        chk_num("meters after reset", base, n_met);
        tally_and_finish();
    end

    initial begin
        repeat (98_000) @(posedge clock_i);
        n_fail++;
        tally_and_finish();
    end
endmodule
